// File: hdl/svpwm_pkg.sv
package svpwm_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 32;
  localparam int unsigned TW = 16;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] OFS_COMPARE_CONTROL = 8'h00;
  localparam logic [AW-1:0] OFS_ACTION_CONTROL  = 8'h04;
  localparam logic [AW-1:0] OFS_FIRST_EDGE      = 8'h08;
  localparam logic [AW-1:0] OFS_SECOND_EDGE     = 8'h0c;
  localparam logic [AW-1:0] OFS_THIRD_COMPARE   = 8'h10;
  localparam logic [AW-1:0] OFS_TIMER_PERIOD    = 8'h14;
  localparam logic [AW-1:0] OFS_TIMER_CONTROL   = 8'h18;
  localparam logic [AW-1:0] OFS_TIMER_COUNT     = 8'h1c;
  localparam logic [AW-1:0] OFS_IRQ_STATUS      = 8'h20;
  localparam logic [AW-1:0] OFS_IRQ_MASK        = 8'h24;

  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  // compare_control_reg
  localparam int unsigned CC_ENABLE = 0;
  localparam int unsigned CC_SVMODE = 1;
  localparam int unsigned CC_RLD_LO = 2;
  localparam int unsigned CC_RLD_HI = 3;
  localparam logic [1:0] RLD_UNDERFLOW  = 2'h0;
  localparam logic [1:0] RLD_UF_OR_PRD  = 2'h1;
  localparam logic [1:0] RLD_IMMEDIATE  = 2'h2;
  // action_control_reg
  localparam int unsigned AC_DIR    = 15;
  localparam int unsigned AC_PAT_HI = 14;
  localparam int unsigned AC_PAT_LO = 12;
  localparam int unsigned AC_POL_HI = 5;
  localparam int unsigned AC_POL_LO = 0;
  // timer control
  localparam int unsigned TC_RUN = 0;
  // status / mask bits
  localparam int unsigned NEV      = 5;
  localparam int unsigned EV_UFL   = 0;
  localparam int unsigned EV_PRD   = 1;
  localparam int unsigned EV_CMP1  = 2;
  localparam int unsigned EV_CMP2  = 3;
  localparam int unsigned EV_CMP3  = 4;

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [TW-1:0] RST_REG16  = 16'h0000;
  localparam logic [TW-1:0] RST_PERIOD = 16'hffff;
  localparam logic [2:0]    PAT_ZERO   = 3'h0;
  localparam logic [1:0]    RESP_OKAY  = 2'h0;
  localparam logic [1:0]    RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // base timer to sequencer
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [TW-1:0] cnt;
    logic          up;
    logic          ufl;
    logic          prd;
  } svpwm_tmr_t;

endpackage

// File: hdl/svpwm_timer.sv
`timescale 1ns/1ps
module svpwm_timer import svpwm_pkg::*; (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire logic          ce,
  // control
  input  wire logic          run,
  input  wire logic [TW-1:0] period,
  // state out
  output svpwm_tmr_t         tmr
);

  typedef struct packed {
    logic [TW-1:0] cnt;
    logic          up;
  } svpwm_tstate_t;

  svpwm_tstate_t st_ff;
  svpwm_tstate_t nxt_st;

  // continuous up/down: 0 -> period -> 0, direction flips at both ends
  always_comb begin
    nxt_st = st_ff;
    if (run) begin
      if (st_ff.up) begin
        if (st_ff.cnt >= period) begin
          nxt_st.up  = 1'b0;
          nxt_st.cnt = st_ff.cnt - 16'h0001;
        end else begin
          nxt_st.cnt = st_ff.cnt + 16'h0001;
        end
      end else begin
        if (st_ff.cnt == RST_REG16) begin
          nxt_st.up  = 1'b1;
          nxt_st.cnt = 16'h0001;
        end else begin
          nxt_st.cnt = st_ff.cnt - 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign tmr.cnt = st_ff.cnt;
  assign tmr.up  = st_ff.up;
  assign tmr.ufl = run && !st_ff.up && (st_ff.cnt == RST_REG16);
  assign tmr.prd = run && st_ff.up && (st_ff.cnt >= period);

endmodule // svpwm_timer

// File: hdl/svpwm_seq.sv
// Operation
// - each period starts with outputs at the first pattern from the action register
// - up-count first-edge match steps pattern 60 degrees, direction bit chooses way
// - up-count second-edge match goes to zero pattern one bit from second
// - down-count second-edge match returns from zero pattern to second pattern
// - down-count first-edge match returns to first pattern, symmetric waveform
// - pattern bit one: upper drive on, lower off; zero: reverse
// - neighbouring nonzero patterns in rotation differ in one bit only
// - third compare still matched against timer, sets flag, may interrupt
// - output transitions lag the compare match by one clock
// - both compares zero in space vector mode forces all outputs inactive
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module svpwm_seq import svpwm_pkg::*; (
  // clock, reset, enable
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire logic          ce,
  // axi4-lite write address
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [AW-1:0] s_axi_awaddr,
  // axi4-lite write data
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  input  wire logic [DW-1:0] s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  // axi4-lite write response
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  output logic [1:0]         s_axi_bresp,
  // axi4-lite read address
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  input  wire logic [AW-1:0] s_axi_araddr,
  // axi4-lite read data
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output logic [DW-1:0]      s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  // gate drive
  output logic [2:0]         upper_leg_drive,
  output logic [2:0]         lower_leg_drive,
  // interrupt
  output logic               irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [TW-1:0]  ccon;
    logic [TW-1:0]  actr;
    logic [TW-1:0]  actr_act;
    logic [TW-1:0]  cmp1;
    logic [TW-1:0]  cmp2;
    logic [TW-1:0]  cmp3;
    logic [TW-1:0]  cmp1_act;
    logic [TW-1:0]  cmp2_act;
    logic [TW-1:0]  cmp3_act;
    logic [TW-1:0]  period;
    logic           run;
    logic [2:0]     pat;
    logic [NEV-1:0] sts;
    logic [NEV-1:0] msk;
    logic [AW-1:0]  awaddr;
    logic           aw_have;
    logic [DW-1:0]  wdata;
    logic [3:0]     wstrb;
    logic           w_have;
    logic           awready;
    logic           wready;
    logic           bvalid;
    logic [1:0]     bresp;
    logic           arready;
    logic           rvalid;
    logic [DW-1:0]  rdata;
    logic [1:0]     rresp;
    logic [2:0]     upper;
    logic [2:0]     lower;
    logic           irq;
  } svpwm_state_t;

  svpwm_state_t st_ff;
  svpwm_state_t nxt_st;
  svpwm_tmr_t   tmr;

  // ----------------------------------------------------------------
  // base timer
  // ----------------------------------------------------------------
  svpwm_timer u_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .run     (st_ff.run),
    .period  (st_ff.period),
    .tmr     (tmr)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // one step along the hexagon; each neighbour differs in one bit
  function automatic logic [2:0] rotate(input logic [2:0] p, input logic fwd);
    logic [2:0] r;
    r = p;
    unique case (p)
      3'h4:    r = fwd ? 3'h6 : 3'h5;
      3'h6:    r = fwd ? 3'h2 : 3'h4;
      3'h2:    r = fwd ? 3'h3 : 3'h6;
      3'h3:    r = fwd ? 3'h1 : 3'h2;
      3'h1:    r = fwd ? 3'h5 : 3'h3;
      3'h5:    r = fwd ? 3'h4 : 3'h1;
      default: r = p;
    endcase
    return r;
  endfunction

  function automatic logic [TW-1:0] merge16(input logic [TW-1:0] old, input logic [DW-1:0] d,
                                            input logic [3:0] be);
    logic [TW-1:0] m;
    m = old;
    if (be[0]) m[7:0]  = d[7:0];
    if (be[1]) m[15:8] = d[15:8];
    return m;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [2:0]     first_pat;
  logic [2:0]     second_pat;
  logic [2:0]     zero_pat;
  logic           m1;
  logic           m2;
  logic           m3;
  logic           sv_on;
  logic           outs_idle;
  logic           reload_cmp;
  logic [NEV-1:0] ev;
  logic           wr_fire;
  logic           rd_fire;
  logic [DW-1:0]  rd_val;
  logic           rd_ok;
  logic           wr_ok;
  logic [AW-1:0]  wa;

  always_comb begin
    nxt_st = st_ff;

    // matches against the active compare values
    m1 = tmr.cnt == st_ff.cmp1_act;
    m2 = tmr.cnt == st_ff.cmp2_act;
    m3 = tmr.cnt == st_ff.cmp3_act;
    ev = '0;
    ev[EV_UFL]  = tmr.ufl;
    ev[EV_PRD]  = tmr.prd;
    ev[EV_CMP1] = st_ff.run && m1;
    ev[EV_CMP2] = st_ff.run && m2;
    ev[EV_CMP3] = st_ff.run && m3;

    // shadow reloads: pattern always at underflow, compares per reload mode
    if (tmr.ufl) begin
      nxt_st.actr_act = st_ff.actr;
    end
    unique case (st_ff.ccon[CC_RLD_HI:CC_RLD_LO])
      RLD_UF_OR_PRD: reload_cmp = tmr.ufl || tmr.prd;
      RLD_IMMEDIATE: reload_cmp = 1'b1;
      default:       reload_cmp = tmr.ufl;
    endcase
    if (reload_cmp) begin
      nxt_st.cmp1_act = st_ff.cmp1;
      nxt_st.cmp2_act = st_ff.cmp2;
      nxt_st.cmp3_act = st_ff.cmp3;
    end

    // pattern sequencing uses the action values after this cycle's reload
    first_pat  = nxt_st.actr_act[AC_PAT_HI:AC_PAT_LO];
    second_pat = rotate(first_pat, nxt_st.actr_act[AC_DIR]);
    zero_pat   = {3{~^second_pat}};
    sv_on      = st_ff.ccon[CC_ENABLE] && st_ff.ccon[CC_SVMODE];
    if (tmr.ufl) begin
      nxt_st.pat = first_pat;
    end
    if (st_ff.run && tmr.up && m1) begin
      nxt_st.pat = second_pat;
    end
    if (st_ff.run && tmr.up && m2) begin
      nxt_st.pat = zero_pat;
    end
    if (st_ff.run && !tmr.up && m2) begin
      nxt_st.pat = second_pat;
    end
    if (st_ff.run && !tmr.up && m1 && !tmr.ufl) begin
      nxt_st.pat = first_pat;
    end

    // drive flops sit one clock behind the match
    outs_idle = !sv_on ||
                ((st_ff.cmp1_act == RST_REG16) && (st_ff.cmp2_act == RST_REG16));
    for (int i = 0; i < 3; i++) begin
      if (outs_idle) begin
        nxt_st.upper[i] = ~st_ff.actr_act[AC_POL_LO + 2*i];
        nxt_st.lower[i] = ~st_ff.actr_act[AC_POL_LO + 2*i + 1];
      end else begin
        nxt_st.upper[i] = ~(nxt_st.pat[i] ^ st_ff.actr_act[AC_POL_LO + 2*i]);
        nxt_st.lower[i] = ~(~nxt_st.pat[i] ^ st_ff.actr_act[AC_POL_LO + 2*i + 1]);
      end
    end

    // axi write channels, taken in either order
    if (s_axi_awvalid && st_ff.awready) begin
      nxt_st.awaddr  = s_axi_awaddr;
      nxt_st.aw_have = 1'b1;
    end
    if (s_axi_wvalid && st_ff.wready) begin
      nxt_st.wdata  = s_axi_wdata;
      nxt_st.wstrb  = s_axi_wstrb;
      nxt_st.w_have = 1'b1;
    end
    wr_fire = st_ff.aw_have && st_ff.w_have && !st_ff.bvalid;
    wa      = st_ff.awaddr;
    wr_ok   = 1'b1;
    if (wr_fire) begin
      unique case (wa)
        OFS_COMPARE_CONTROL: nxt_st.ccon   = merge16(st_ff.ccon, st_ff.wdata, st_ff.wstrb);
        OFS_ACTION_CONTROL:  nxt_st.actr   = merge16(st_ff.actr, st_ff.wdata, st_ff.wstrb);
        OFS_FIRST_EDGE:      nxt_st.cmp1   = merge16(st_ff.cmp1, st_ff.wdata, st_ff.wstrb);
        OFS_SECOND_EDGE:     nxt_st.cmp2   = merge16(st_ff.cmp2, st_ff.wdata, st_ff.wstrb);
        OFS_THIRD_COMPARE:   nxt_st.cmp3   = merge16(st_ff.cmp3, st_ff.wdata, st_ff.wstrb);
        OFS_TIMER_PERIOD:    nxt_st.period = merge16(st_ff.period, st_ff.wdata, st_ff.wstrb);
        OFS_TIMER_CONTROL: begin
          if (st_ff.wstrb[0]) nxt_st.run = st_ff.wdata[TC_RUN];
        end
        OFS_IRQ_MASK: begin
          if (st_ff.wstrb[0]) nxt_st.msk = st_ff.wdata[NEV-1:0];
        end
        OFS_TIMER_COUNT, OFS_IRQ_STATUS: wr_ok = 1'b1;
        default: wr_ok = 1'b0;
      endcase
      nxt_st.aw_have = 1'b0;
      nxt_st.w_have  = 1'b0;
      nxt_st.bvalid  = 1'b1;
      nxt_st.bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    nxt_st.awready = !nxt_st.aw_have && !nxt_st.bvalid;
    nxt_st.wready  = !nxt_st.w_have && !nxt_st.bvalid;

    // axi read; status is cleared by its read, a same-cycle event survives
    rd_fire = s_axi_arvalid && st_ff.arready;
    rd_val  = '0;
    rd_ok   = 1'b1;
    unique case (s_axi_araddr)
      OFS_COMPARE_CONTROL: rd_val[TW-1:0]  = st_ff.ccon;
      OFS_ACTION_CONTROL:  rd_val[TW-1:0]  = st_ff.actr;
      OFS_FIRST_EDGE:      rd_val[TW-1:0]  = st_ff.cmp1;
      OFS_SECOND_EDGE:     rd_val[TW-1:0]  = st_ff.cmp2;
      OFS_THIRD_COMPARE:   rd_val[TW-1:0]  = st_ff.cmp3;
      OFS_TIMER_PERIOD:    rd_val[TW-1:0]  = st_ff.period;
      OFS_TIMER_CONTROL:   rd_val[TC_RUN]  = st_ff.run;
      OFS_TIMER_COUNT:     rd_val[TW-1:0]  = tmr.cnt;
      OFS_IRQ_STATUS:      rd_val[NEV-1:0] = st_ff.sts;
      OFS_IRQ_MASK:        rd_val[NEV-1:0] = st_ff.msk;
      default:             rd_ok = 1'b0;
    endcase
    if (rd_fire) begin
      nxt_st.rdata  = rd_val;
      nxt_st.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
      nxt_st.rvalid = 1'b1;
      if (s_axi_araddr == OFS_IRQ_STATUS) begin
        nxt_st.sts = '0;
      end
    end
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    nxt_st.arready = !nxt_st.rvalid;
    nxt_st.sts = nxt_st.sts | ev;
    nxt_st.irq = |(nxt_st.sts & nxt_st.msk);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff        <= '0;
      st_ff.period <= RST_PERIOD;
      st_ff.upper  <= 3'h7;
      st_ff.lower  <= 3'h7;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready   = st_ff.awready;
  assign s_axi_wready    = st_ff.wready;
  assign s_axi_bvalid    = st_ff.bvalid;
  assign s_axi_bresp     = st_ff.bresp;
  assign s_axi_arready   = st_ff.arready;
  assign s_axi_rvalid    = st_ff.rvalid;
  assign s_axi_rdata     = st_ff.rdata;
  assign s_axi_rresp     = st_ff.rresp;
  assign upper_leg_drive = st_ff.upper;
  assign lower_leg_drive = st_ff.lower;
  assign irq             = st_ff.irq;

endmodule // svpwm_seq

// File: verif/svpwm_chk_assertions.sv
`timescale 1ns/1ps
module svpwm_chk import svpwm_pkg::*; (
  // clock and reset
  input wire logic          clk,
  input wire logic          sys_rst,
  input wire logic          ce,
  // register bus
  input wire logic          s_axi_awvalid,
  input wire logic          s_axi_awready,
  input wire logic          s_axi_wvalid,
  input wire logic          s_axi_wready,
  input wire logic          s_axi_bvalid,
  input wire logic          s_axi_bready,
  input wire logic [1:0]    s_axi_bresp,
  input wire logic          s_axi_arvalid,
  input wire logic          s_axi_arready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic          s_axi_rvalid,
  input wire logic          s_axi_rready,
  input wire logic [DW-1:0] s_axi_rdata,
  input wire logic [1:0]    s_axi_rresp,
  // gate drive and interrupt
  input wire logic [2:0]    upper_leg_drive,
  input wire logic [2:0]    lower_leg_drive,
  input wire logic          irq
);
  // ----------------------------------------------------------------
  // recent register accesses
  // ----------------------------------------------------------------
  // irq may only drop a few cycles after a status read or a mask write
  logic [5:0] acc_ff;
  always_ff @(posedge clk) begin
    if (sys_rst) acc_ff <= 6'h00;
    else acc_ff <= {acc_ff[4:0], (s_axi_arvalid & s_axi_arready) | (s_axi_awvalid & s_axi_awready)};
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  rd_unmapped_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h28
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  freeze_out_a: assert property (!ce |=> $stable(upper_leg_drive) && $stable(lower_leg_drive) && $stable(irq))
    else $error("outputs moved with clock enable low");
  irq_sticky_a: assert property ($fell(irq) |-> acc_ff != 6'h00)
    else $error("interrupt dropped without access");

  cover property (s_axi_bvalid && s_axi_bready);
  cover property ($rose(irq));
  cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule // svpwm_chk

bind svpwm_seq svpwm_chk chk_u (.clk, .sys_rst, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .upper_leg_drive,
  .lower_leg_drive, .irq);

// File: verif/svpwm_inverter.sv
`timescale 1ns/1ps
module svpwm_inverter (
  // gate drive from the sequencer
  input wire logic [2:0] upper_leg_drive,
  input wire logic [2:0] lower_leg_drive,
  // leg state seen by the motor
  output logic     [2:0] leg_state,
  output logic     [2:0] floating,
  output logic           shoot
);
  // active-high gates: both on shorts the supply, both off leaves the leg floating
  always_comb begin
    leg_state = upper_leg_drive & ~lower_leg_drive;
    floating  = ~(upper_leg_drive | lower_leg_drive);
    shoot     = |(upper_leg_drive & lower_leg_drive);
  end
endmodule // svpwm_inverter

// File: verif/space_vector_pwm_sequencer_tb.sv
`timescale 1ns/1ps
module space_vector_pwm_sequencer_tb import svpwm_pkg::*; ;
  logic          clk = 1'b0, sys_rst = 1'b1, ce = 1'b1;
  logic          s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic          s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [AW-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [DW-1:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]    s_axi_wstrb = 4'hf;
  logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, shoot;
  logic [1:0]    s_axi_bresp, s_axi_rresp;
  logic [2:0]    upper_leg_drive, lower_leg_drive, leg_state, floating;
  int            n_errors = 0, cmp_count = 0;
  localparam logic [2:0] ROT [6] = '{3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h5};

  svpwm_seq dut_u (.clk, .sys_rst, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .upper_leg_drive, .lower_leg_drive, .irq);
  svpwm_inverter inv_u (.upper_leg_drive, .lower_leg_drive, .leg_state, .floating, .shoot);

  initial begin
    forever #4 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("compares=%0d mismatches=%0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, ed);
    chk(r, er);
  endtask

  // clear status, then poll until a fresh underflow shows new settings are live
  task automatic wufl;
    logic [31:0] d;
    logic [1:0]  r;
    rd(OFS_IRQ_STATUS, d, r);
    do rd(OFS_IRQ_STATUS, d, r);
    while (d[EV_UFL] !== 1'b1);
  endtask

  task automatic wlev(input logic [2:0] v, input logic same);
    // step off the launching edge first, the drive flops may be switching on it
    @(negedge clk);
    for (int k = 0; k < 200 && ((leg_state === v) != same); k++) @(negedge clk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk(upper_leg_drive, 3'h7);
    chk(lower_leg_drive, 3'h7);
    chk(irq, 1'b0);
    rdc(OFS_TIMER_PERIOD, 32'h0000ffff, RESP_OKAY);
    rdc(OFS_FIRST_EDGE, 32'h0, RESP_OKAY);
    rdc(8'h40, 32'h0, RESP_SLVERR);
    wr(8'h40, 32'h1234, RESP_SLVERR);
    $display("test reset done");
  endtask

  task automatic t_setup;
    logic [2:0] u;
    wr(OFS_ACTION_CONTROL, 32'h0000403f, RESP_OKAY);
    wr(OFS_FIRST_EDGE, 32'h4, RESP_OKAY);
    wr(OFS_SECOND_EDGE, 32'h9, RESP_OKAY);
    wr(OFS_TIMER_PERIOD, 32'h14, RESP_OKAY);
    wr(OFS_COMPARE_CONTROL, 32'h3, RESP_OKAY);
    wr(OFS_TIMER_CONTROL, 32'h1, RESP_OKAY);
    wufl();
    @(posedge clk);
    ce <= 1'b0;
    @(negedge clk);
    u = upper_leg_drive;
    repeat (8) @(negedge clk);
    chk(upper_leg_drive, u);
    @(posedge clk);
    ce <= 1'b1;
    $display("test setup done");
  endtask

  task automatic t_seq;
    logic [2:0] p, r, z;
    logic       fwd;
    for (int i = 0; i < 12; i++) begin
      fwd = (i < 6);
      p = ROT[i % 6];
      r = fwd ? ROT[(i + 1) % 6] : ROT[(i + 5) % 6];
      z = ($countones(r) == 2) ? 3'h7 : 3'h0;
      wr(OFS_ACTION_CONTROL, {16'h0000, fwd, p, 12'h03f}, RESP_OKAY);
      wufl();
      wlev(p, 1'b1);
      chk(leg_state, p);
      wlev(p, 1'b0);
      chk(leg_state, r);
      wlev(r, 1'b0);
      chk(leg_state, z);
      wlev(z, 1'b0);
      chk(leg_state, r);
      wlev(r, 1'b0);
      chk(leg_state, p);
      chk({shoot, floating}, 4'h0);
    end
    $display("test sequence done");
  endtask

  task automatic t_zero;
    wr(OFS_FIRST_EDGE, 32'h0, RESP_OKAY);
    wr(OFS_SECOND_EDGE, 32'h0, RESP_OKAY);
    wufl();
    @(negedge clk);
    chk({upper_leg_drive, lower_leg_drive}, 6'h00);
    // immediate reload: new compares must lift the idle state long before the next underflow
    wr(OFS_COMPARE_CONTROL, {28'h0000000, RLD_IMMEDIATE, 2'h3}, RESP_OKAY);
    wr(OFS_FIRST_EDGE, 32'h4, RESP_OKAY);
    wr(OFS_SECOND_EDGE, 32'h9, RESP_OKAY);
    @(negedge clk);
    chk(floating, 3'h0);
    wr(OFS_COMPARE_CONTROL, 32'h3, RESP_OKAY);
    $display("test zero done");
  endtask

  task automatic t_irq;
    logic [31:0] d;
    logic [1:0]  r;
    wr(OFS_THIRD_COMPARE, 32'h7, RESP_OKAY);
    wufl();
    // let the third compare match go by so a masked flag is really pending
    repeat (8) @(negedge clk);
    chk(irq, 1'b0);
    wr(OFS_IRQ_MASK, 32'h1 << EV_CMP3, RESP_OKAY);
    @(negedge clk);
    for (int k = 0; k < 200 && irq !== 1'b1; k++) @(negedge clk);
    chk(irq, 1'b1);
    rd(OFS_IRQ_STATUS, d, r);
    chk(d[EV_CMP3], 1'b1);
    wr(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
    repeat (3) @(negedge clk);
    chk(irq, 1'b0);
    $display("test interrupt done");
  endtask

  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    t_reset();
    t_setup();
    t_seq();
    t_zero();
    t_irq();
    wrap_up();
  end

  initial begin
    #200000;
    n_errors++;
    wrap_up();
  end
endmodule // space_vector_pwm_sequencer_tb
